//--- logic/mrlc_core.sv
// Purpose: reset sources, control register, measurement loop and temperature result
// Assumes: register port from the serial engine, converter answers with a done pulse
// Notes: pin inputs pass a three-stage synchroniser; memory is not cleared by reset
`timescale 1ns/1ps
module mrlc_core
    import mrlc_pkg::*;
#(
    parameter int unsigned P_PULSE_CYC = PULSE_CYC,
    parameter int unsigned P_SLOT_CYC = SLOT_CYC,
    parameter logic [7:0] P_COMPANY_ID = 8'h5a,  // arbitrary value
    parameter logic [7:0] P_STEPPING = 8'h02  // arbitrary value
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // register port
    input wire mrlc_req_t i_req,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // converter
    input wire mrlc_conv_t i_conv,
    output logic o_conv_start,
    output logic [3:0] o_conv_chan,
    output logic [7:0] o_dac_code,
    // open-drain pins
    input wire logic i_rst_pin,
    output logic o_rst_pin_out,
    output logic o_rst_pin_oe,
    input wire logic i_chassis_intrusion_pin,
    output logic o_chassis_intrusion_pin_out,
    output logic o_chassis_intrusion_pin_oe,
    output logic o_int_n
);
    typedef struct packed {
        logic [RAM_WORDS-1:0][7:0] ram;
        logic [7:0] dac;
        logic [7:0] cfg;
        logic [7:0] st1;
        logic [7:0] st2;
        logic [7:0] msk1;
        logic [7:0] msk2;
        logic [7:0] chsclr;
        logic [7:0] tcfg;
        logic [2:0] rpin;  // reset pin synchroniser
        logic rpin_f;
        logic [2:0] cpin;  // chassis pin synchroniser
        logic cpin_f;
        logic driving;
        logic [PCNT_W-1:0] pcnt;
        logic [2:0] blank;
        mrlc_mstate_t ms;
        logic [3:0] chan;
        logic [SCNT_W-1:0] scnt;
        logic conv_start;
        logic [7:0] rdata;
        logic rvalid;
        logic rst_oe;
        logic chs_oe;
        logic int_n;
    } mrlc_state_t;

    mrlc_state_t st_q;
    mrlc_state_t st_d;

    // memory index of the result slot for each channel in loop order
    function automatic logic [4:0] res_idx(input logic [3:0] ch);
        unique case (ch)
            4'h0: res_idx = 5'h07;
            4'h1: res_idx = 5'h06;
            4'h2: res_idx = 5'h04;
            4'h3: res_idx = 5'h03;
            4'h4: res_idx = 5'h02;
            4'h5: res_idx = 5'h00;
            4'h6: res_idx = 5'h01;
            4'h7: res_idx = 5'h08;
            default: res_idx = 5'h09;
        endcase
    endfunction : res_idx

    // limit check: temperature signed, fans high limit only
    function automatic logic viol(input logic [3:0] ch, input logic [7:0] v, input logic [7:0] hi,
                                  input logic [7:0] lo);
        if (ch == CH_TEMP) begin
            viol = ($signed(v) > $signed(hi)) || ($signed(v) < $signed(lo));
        end else if (ch >= CH_FAN1) begin
            viol = v > hi;
        end else begin
            viol = (v > hi) || (v < lo);
        end
    endfunction : viol

    // restore the register defaults that both initialisation and pin reset touch
    function automatic mrlc_state_t init_regs(input mrlc_state_t s);
        init_regs = s;
        init_regs.cfg = CFG_RST;
        init_regs.st1 = ZERO_RST;
        init_regs.st2 = ZERO_RST;
        init_regs.msk1 = ZERO_RST;
        init_regs.msk2 = ZERO_RST;
        init_regs.chsclr = ZERO_RST;
        init_regs.tcfg = TCFG_RST;
    endfunction : init_regs

    logic run_ok;
    logic [4:0] ridx;
    logic [4:0] hidx;
    logic [4:0] lidx;
    logic [4:0] widx;
    logic [7:0] res;
    logic hw_req;
    logic sw_req;

    // next-state logic
    always_comb begin
        st_d = st_q;
        st_d.conv_start = 1'b0;
        st_d.rvalid = 1'b0;
        run_ok = st_q.cfg[CFG_START] && !st_q.cfg[CFG_INTCLR];
        ridx = res_idx(st_q.chan);
        hidx = 5'(LIM_HI_BASE + {st_q.chan, 1'b0});
        lidx = 5'(LIM_LO_BASE + {st_q.chan, 1'b0});
        widx = 5'(i_req.addr - A_RAM_LO);
        res = i_conv.data[8:1];
        // pin synchronisers, level accepted once stages two and three agree
        st_d.rpin = {st_q.rpin[1:0], i_rst_pin};
        st_d.cpin = {st_q.cpin[1:0], i_chassis_intrusion_pin};
        if (st_q.rpin[1] == st_q.rpin[2]) begin
            st_d.rpin_f = st_q.rpin[2];
        end
        if (st_q.cpin[1] == st_q.cpin[2]) begin
            st_d.cpin_f = st_q.cpin[2];
        end
        // register writes and reads, served in standby too
        if (i_req.wr) begin
            if (i_req.addr == A_DAC) begin
                st_d.dac = i_req.wdata;
            end else if (i_req.addr >= A_RAM_LO && i_req.addr <= A_RAM_HI) begin
                st_d.ram[widx] = i_req.wdata;
            end else if (i_req.addr == A_CFG) begin
                if (i_req.wdata[CFG_INIT]) begin
                    st_d = init_regs(st_d);
                end else begin
                    st_d.cfg = i_req.wdata;
                    st_d.cfg[CFG_SWRST] = i_req.wdata[CFG_SWRST] && st_q.msk2[MSK2_RSTSEL];
                end
            end else if (i_req.addr == A_MSK1) begin
                st_d.msk1 = i_req.wdata;
            end else if (i_req.addr == A_MSK2) begin
                st_d.msk2 = i_req.wdata;
            end else if (i_req.addr == A_CHSCLR) begin
                st_d.chsclr = {i_req.wdata[CHSCLR_BIT], 7'h00};
            end else if (i_req.addr == A_TCFG) begin
                st_d.tcfg[1:0] = i_req.wdata[1:0];
            end
        end
        if (i_req.rd) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = 8'h00;
            if (i_req.addr == A_DAC) begin
                st_d.rdata = st_q.dac;
            end else if (i_req.addr >= A_RAM_LO && i_req.addr <= A_RAM_HI) begin
                st_d.rdata = st_q.ram[widx];
            end else if (i_req.addr == A_COMPANY) begin
                st_d.rdata = P_COMPANY_ID;
            end else if (i_req.addr == A_STEP) begin
                st_d.rdata = P_STEPPING;
            end else if (i_req.addr == A_CFG) begin
                st_d.rdata = st_q.cfg;
            end else if (i_req.addr == A_ST1) begin
                st_d.rdata = st_q.st1;
                st_d.st1 = 8'h00;  // clear on read, later sets win
            end else if (i_req.addr == A_ST2) begin
                st_d.rdata = st_q.st2;
                st_d.st2 = 8'h00;
            end else if (i_req.addr == A_MSK1) begin
                st_d.rdata = st_q.msk1;
            end else if (i_req.addr == A_MSK2) begin
                st_d.rdata = st_q.msk2;
            end else if (i_req.addr == A_CHSCLR) begin
                st_d.rdata = st_q.chsclr;
            end else if (i_req.addr == A_TCFG) begin
                st_d.rdata = st_q.tcfg;
            end
        end
        // reset pin: pulses and external pull-low detection
        hw_req = !st_q.rpin_f && !st_q.driving && st_q.blank == 3'h0;
        sw_req = st_q.cfg[CFG_SWRST];
        if (hw_req || sw_req) begin
            st_d.driving = 1'b1;
            st_d.pcnt = PCNT_W'(P_PULSE_CYC - 1);
            st_d.cfg[CFG_SWRST] = 1'b0;
            if (hw_req) begin
                st_d = init_regs(st_d);
            end
        end else if (st_q.driving) begin
            if (st_q.pcnt == '0) begin
                st_d.driving = 1'b0;
                st_d.blank = BLANK_CYC;
            end else begin
                st_d.pcnt = st_q.pcnt - 1'b1;
            end
        end else if (st_q.blank != 3'h0) begin
            st_d.blank = st_q.blank - 1'b1;
        end
        // measurement loop
        if (st_q.scnt != '0) begin
            st_d.scnt = st_q.scnt - 1'b1;
        end
        unique case (st_q.ms)
            MS_IDLE: begin
                if (run_ok) begin
                    st_d.chan = CH_TEMP;
                    st_d.ms = MS_CONV;
                end
            end
            MS_CONV: begin
                st_d.conv_start = 1'b1;
                st_d.scnt = SCNT_W'(P_SLOT_CYC - 1);
                st_d.ms = MS_WAIT;
            end
            MS_WAIT, MS_PACE: begin
                if (st_q.ms == MS_WAIT && i_conv.done) begin
                    st_d.ram[ridx] = res;
                    if (st_q.chan == CH_TEMP) begin
                        st_d.tcfg[TCFG_HALF] = i_conv.data[0];
                    end
                    if (viol(st_q.chan, res, st_q.ram[hidx], st_q.ram[lidx])) begin
                        if (st_q.chan == CH_LAST) begin
                            st_d.st2[ST2_FAN2] = 1'b1;
                        end else begin
                            st_d.st1[st_q.chan[2:0]] = 1'b1;
                        end
                    end
                    st_d.ms = MS_PACE;
                end else if (st_q.scnt == '0) begin
                    if (st_q.chan != CH_LAST) begin
                        st_d.chan = st_q.chan + 1'b1;
                        st_d.ms = MS_CONV;
                    end else if (run_ok) begin
                        st_d.chan = CH_TEMP;
                        st_d.ms = MS_CONV;
                    end else begin
                        st_d.ms = MS_IDLE;
                    end
                end
            end
        endcase
        // chassis input and clear drive
        st_d.chs_oe = !(st_d.cfg[CFG_CHSDRV] || st_d.chsclr[CHSCLR_BIT]);
        if (st_q.cpin_f && st_q.chs_oe) begin
            st_d.st2[ST2_CHS] = 1'b1;
        end
        // pin and interrupt outputs
        st_d.rst_oe = !st_d.driving;
        st_d.int_n = !(st_d.cfg[CFG_INTEN] && !st_d.cfg[CFG_INTCLR]
            && ((|(st_d.st1 & ~st_d.msk1)) || (|(st_d.st2[6:0] & ~st_d.msk2[6:0]))));
        // power-on reset: everything but the measurement memory
        if (i_srst) begin
            st_d = '0;
            st_d.ram = st_q.ram;
            st_d = init_regs(st_d);
            st_d.dac = DAC_RST;
            st_d.rpin = 3'h7;
            st_d.rpin_f = 1'b1;
            st_d.driving = 1'b1;
            st_d.pcnt = PCNT_W'(P_PULSE_CYC - 1);
            st_d.ms = MS_IDLE;
            st_d.rst_oe = 1'b0;
            st_d.chs_oe = 1'b1;
            st_d.int_n = 1'b1;
        end
    end

    // state register
    always_ff @(posedge i_sys_clk) begin
        st_q <= st_d;
    end

    // outputs straight from the state register, pin data outputs tied low
    assign o_reg_rdata = st_q.rdata;
    assign o_reg_rvalid = st_q.rvalid;
    assign o_conv_start = st_q.conv_start;
    assign o_conv_chan = st_q.chan;
    assign o_dac_code = st_q.dac;
    assign o_rst_pin_out = 1'b0;
    assign o_rst_pin_oe = st_q.rst_oe;
    assign o_chassis_intrusion_pin_out = 1'b0;
    assign o_chassis_intrusion_pin_oe = st_q.chs_oe;
    assign o_int_n = st_q.int_n;

    // helper: length of the current low drive, previous start channel
    int low_len;
    logic [3:0] last_chan;
    always_ff @(posedge i_sys_clk) begin
        low_len <= (i_srst || o_rst_pin_oe) ? 0 : low_len + 1;  // known zero from reset, no unknown at release
        if (o_conv_start) begin
            last_chan <= o_conv_chan;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    // a control register write carrying one chosen bit
    sequence s_cfg_write(int b);
        i_req.wr && i_req.addr == A_CFG && i_req.wdata[b];
    endsequence

    chk_por_drive: assert property (disable iff (1'b0) i_srst |=> !o_rst_pin_oe)
        else $error("reset pin not driven after power-on reset");
    chk_pulse_min_len: assert property ($rose(o_rst_pin_oe) |-> low_len >= P_PULSE_CYC)
        else $error("reset pulse shorter than minimum");
    chk_swrst_self_clear: assert property ($fell(o_rst_pin_oe) |-> !st_q.cfg[CFG_SWRST])
        else $error("software reset bit still set after pin went active");
    chk_swrst_gate: assert property (s_cfg_write(CFG_SWRST) and !st_q.msk2[MSK2_RSTSEL]
        and !st_q.cfg[CFG_INIT] |=> !st_q.cfg[CFG_SWRST])
        else $error("software reset accepted without reset mode");
    chk_init_defaults: assert property (s_cfg_write(CFG_INIT) and !i_req.rd
        |=> st_q.cfg[CFG_START] == 1'b0 && st_q.msk1 == ZERO_RST && $stable(o_dac_code))
        else $error("initialisation did not restore defaults");
    chk_int_gate_off: assert property (!st_q.cfg[CFG_INTEN] || st_q.cfg[CFG_INTCLR] |-> o_int_n)
        else $error("interrupt active while gated");
    chk_loop_order: assert property (o_conv_start && o_conv_chan != CH_TEMP
        |-> o_conv_chan == 4'(last_chan + 1'b1))
        else $error("measurement order broken");
    // idle, then the start state, then the start pulse: two cycles back from the pulse
    chk_restart_temp: assert property ($past(st_q.ms, 2) == MS_IDLE && o_conv_start
        |-> o_conv_chan == CH_TEMP)
        else $error("loop restart did not begin with temperature");
    chk_temp_store: assert property (st_q.ms == MS_WAIT && i_conv.done && st_q.chan == CH_TEMP
        |=> st_q.ram[7] == $past(i_conv.data[8:1]) && st_q.tcfg[TCFG_HALF] == $past(i_conv.data[0]))
        else $error("temperature result not stored");
    chk_clear_halt: assert property (st_q.cfg[CFG_INTCLR] && st_q.ms == MS_IDLE |=> st_q.ms == MS_IDLE)
        else $error("loop left standby while interrupt clear was set");
    chk_chs_drive: assert property (st_q.cfg[CFG_CHSDRV] |-> !o_chassis_intrusion_pin_oe)
        else $error("chassis pin not driven");
endmodule : mrlc_core

//--- logic/mrlc_pkg.sv
// Purpose: constants and types for the monitor reset and loop control core
// Assumes: 25 MHz system clock, register port driven by the serial protocol engine
// Notes: all offsets are internal register addresses of the byte-wide map
// Functional notes
// - power-on reset returns all registers to defaults; measurement memory stays undefined
// - power-on reset drives the system reset pin low at least 20 ms
// - after power-up the measurement loop stays idle until the host starts it
// - reset pin is two-way: driven low on reset, external low causes reset
// - writing control bit 4 pulses reset pin low 20 ms, registers untouched
// - control bit 4 clears itself when the reset pin becomes active
// - software reset pulse only when mask register 2 bit 7 is one
// - control bit 7 restores defaults except memory and analog output, self-clears
// - external low on reset pin: hold low over 20 ms, restore defaults
// - control bit 0 starts the loop when set, stops into standby when clear
// - standby keeps register access and watches reset and chassis inputs
// - control bit 1 enables the interrupt output pin
// - control bit 3 deasserts interrupt, halts loop, keeps status bits
// - control bit 6 drives the chassis pin low to clear the external latch
// - inputs sampled round-robin in fixed order, whole loop about once a second
// - completed results live in measurement memory, readable at any time
// - a stop request lets the current loop finish and store results
// - every restart begins with the temperature measurement
// - latest temperature readable as one byte at location 27h
// - temperature byte is two's complement whole degrees, top bit sign
// - temperature configuration bit 7 shows the half-degree bit
// - each result is checked against its limits, violation sets a status bit
package mrlc_pkg;
    // clock and timing
    localparam int CLK_KHZ = 25000;
    localparam int PULSE_TIME_MS = 20;
    localparam int PULSE_CYC = PULSE_TIME_MS * CLK_KHZ + 1;  // one extra cycle keeps it strictly above
    localparam int LOOP_TIME_MS = 1000;
    localparam int NUM_CHAN = 9;
    localparam int SLOT_CYC = (LOOP_TIME_MS * CLK_KHZ) / NUM_CHAN;
    localparam int PCNT_W = 20;
    localparam int SCNT_W = 24;
    localparam logic [2:0] BLANK_CYC = 3'h6;  // ignore pin echo after release
    // register offsets
    localparam logic [7:0] A_DAC = 8'h19;
    localparam logic [7:0] A_RAM_LO = 8'h20;
    localparam logic [7:0] A_RAM_HI = 8'h3d;
    localparam logic [7:0] A_TEMP = 8'h27;
    localparam logic [7:0] A_COMPANY = 8'h3e;
    localparam logic [7:0] A_STEP = 8'h3f;
    localparam logic [7:0] A_CFG = 8'h40;
    localparam logic [7:0] A_ST1 = 8'h41;
    localparam logic [7:0] A_ST2 = 8'h42;
    localparam logic [7:0] A_MSK1 = 8'h43;
    localparam logic [7:0] A_MSK2 = 8'h44;
    localparam logic [7:0] A_CHSCLR = 8'h46;
    localparam logic [7:0] A_TCFG = 8'h4b;
    // control register fields
    localparam int CFG_START = 0;
    localparam int CFG_INTEN = 1;
    localparam int CFG_INTCLR = 3;
    localparam int CFG_SWRST = 4;
    localparam int CFG_CHSDRV = 6;
    localparam int CFG_INIT = 7;
    localparam int MSK2_RSTSEL = 7;
    localparam int CHSCLR_BIT = 7;
    localparam int TCFG_HALF = 7;
    localparam int ST2_CHS = 4;
    localparam int ST2_FAN2 = 0;
    // reset values
    localparam logic [7:0] CFG_RST = 8'h08;
    localparam logic [7:0] TCFG_RST = 8'h01;
    localparam logic [7:0] DAC_RST = 8'hff;
    localparam logic [7:0] ZERO_RST = 8'h00;
    // measurement memory layout, indices from A_RAM_LO
    localparam int RAM_WORDS = 30;
    localparam logic [4:0] LIM_HI_BASE = 5'h0b;
    localparam logic [4:0] LIM_LO_BASE = 5'h0c;
    localparam logic [3:0] CH_TEMP = 4'h0;
    localparam logic [3:0] CH_FAN1 = 4'h7;
    localparam logic [3:0] CH_LAST = 4'h8;

    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_CONV = 2'b01,
        MS_WAIT = 2'b10,
        MS_PACE = 2'b11
    } mrlc_mstate_t;

    // register port request from the serial engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mrlc_req_t;

    // converter result
    typedef struct packed {
        logic done;
        logic [8:0] data;  // temperature: [8:1] whole degrees, [0] half degree
    } mrlc_conv_t;
endpackage : mrlc_pkg

//--- tb/mrlc_far_model.sv
// Purpose: far-side model: converter, reset pin pull-up and external chassis latch
// Assumes: one answer per converter start, prompt on even channels, slow on odd ones
// Notes: data lines toggle between answers so stale values never pass
`timescale 1ns/1ps
module mrlc_far_model
    import mrlc_pkg::*;
(
    // clock
    input wire logic i_sys_clk,
    // converter side
    input wire logic i_conv_start,
    input wire logic [3:0] i_conv_chan,
    input wire logic [8:0] i_temp,
    input wire logic [7:0] i_volt,
    output mrlc_conv_t o_conv,
    // pins
    input wire logic i_rst_out,
    input wire logic i_rst_oe,
    input wire logic i_ext_low,
    input wire logic i_chs_out,
    input wire logic i_chs_oe,
    input wire logic i_intrude,
    output logic o_rst_pin,
    output logic o_chs_pin
);
    logic [3:0] wait_q = 4'h0;
    logic [3:0] chan_q = 4'h0;
    logic latch_q = 1'b0;
    // reset pin: pull-up, low when the device or an outside source pulls it
    assign o_rst_pin = (!i_rst_oe ? i_rst_out : 1'b1) & !i_ext_low;
    // chassis pin: device drive wins over the latch output
    assign o_chs_pin = !i_chs_oe ? i_chs_out : latch_q;
    // latch and converter answer, done settles at the first edge
    always @(posedge i_sys_clk) begin
        o_conv.done <= 1'b0;
        o_conv.data <= ~o_conv.data;
        if (i_intrude) begin
            latch_q <= 1'b1;
        end else if (!i_chs_oe) begin
            latch_q <= 1'b0;
        end
        if (i_conv_start) begin
            chan_q <= i_conv_chan;
            wait_q <= i_conv_chan[0] ? 4'hc : 4'h1;
        end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
            if (wait_q == 4'h1) begin
                o_conv.done <= 1'b1;
                o_conv.data <= (chan_q == CH_TEMP) ? i_temp : {i_volt, 1'b0};
            end
        end
    end
endmodule : mrlc_far_model

//--- tb/tb_top.sv
// Purpose: self-checking bench for the monitor reset and loop control core
// Assumes: short pulse and slot counts so loops finish quickly
// Notes: register port driven one request at a time with a gap cycle
`timescale 1ns/1ps
module tb_top
    import mrlc_pkg::*;
;
    localparam int P_PULSE = 20;
    localparam int P_SLOT = 30;
    logic clk = 1'b0;
    logic srst = 1'b1;
    mrlc_req_t req = '0;
    logic ext_low = 1'b0;
    logic intrude = 1'b0;
    logic [8:0] temp = 9'h0;
    logic [7:0] volt = 8'h0;
    logic [7:0] rdata, dac, v, t1;
    logic [3:0] chan;
    logic [3:0] exp_chan = 4'h0;
    logic rvalid, conv_start, rst_out, rst_oe, chs_out, chs_oe, int_n, rst_pin, chs_pin, h;
    mrlc_conv_t conv;
    int err_total = 0;
    int checks = 0;
    int starts = 0;
    int n;
    // clock generator
    always #20 clk = ~clk;
    mrlc_core #(.P_PULSE_CYC(P_PULSE), .P_SLOT_CYC(P_SLOT)) uut (.i_sys_clk(clk), .i_srst(srst),
        .i_req(req), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_conv(conv), .o_conv_start(conv_start),
        .o_conv_chan(chan), .o_dac_code(dac), .i_rst_pin(rst_pin), .o_rst_pin_out(rst_out),
        .o_rst_pin_oe(rst_oe), .i_chassis_intrusion_pin(chs_pin), .o_chassis_intrusion_pin_out(chs_out),
        .o_chassis_intrusion_pin_oe(chs_oe), .o_int_n(int_n));
    mrlc_far_model far (.i_sys_clk(clk), .i_conv_start(conv_start), .i_conv_chan(chan), .i_temp(temp),
        .i_volt(volt), .o_conv(conv), .i_rst_out(rst_out), .i_rst_oe(rst_oe), .i_ext_low(ext_low),
        .i_chs_out(chs_out), .i_chs_oe(chs_oe), .i_intrude(intrude), .o_rst_pin(rst_pin), .o_chs_pin(chs_pin));
    function automatic logic [7:0] lim_addr(input int c, input bit hi);
        return 8'(8'h2b + 2 * c + (hi ? 0 : 1));
    endfunction : lim_addr
    function automatic logic [7:0] temp_byte(input int deg);
        return 8'(deg);
    endfunction : temp_byte
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic stop_test;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        check("read valid", 16'(rvalid), 16'h1);
        d = rdata;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check($sformatf("reg %h", a), 16'(d), 16'(exp));
    endtask : rchk
    // waits for the pin drive, then counts the cycles it stays low
    task automatic low_len(output int cnt);
        int k;
        cnt = 0;
        #1;
        for (k = 0; k < 10 && rst_oe; k++) begin
            @(posedge clk);
            #1;
        end
        while (!rst_oe && cnt < 200) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask : low_len
    task automatic wait_starts(input int goal);
        int k;
        for (k = 0; k < 1000 && starts < goal; k++) @(posedge clk);
        check("starts", 16'(starts), 16'(goal));
    endtask : wait_starts
    // channel order watcher
    always @(posedge clk) begin
        if (conv_start === 1'b1) begin
            check("channel", 16'(chan), 16'(exp_chan));
            exp_chan <= (chan == CH_LAST) ? 4'h0 : chan + 4'h1;
            starts <= starts + 1;
        end
    end
    // watchdog
    initial begin
        repeat (10000) @(posedge clk);
        err_total++;
        stop_test();
    end
    // main sequence
    initial begin
        void'($urandom(88));
        repeat (3) @(posedge clk);
        #1;
        check("pin in reset", 16'({rst_oe, rst_pin}), 16'h0);
        @(posedge clk);
        srst <= 1'b0;
        low_len(n);
        check("por pulse", 16'(n >= P_PULSE), 16'h1);
        rchk(A_CFG, CFG_RST);
        rchk(A_TCFG, TCFG_RST);
        rchk(A_MSK2, ZERO_RST);
        rchk(A_DAC, DAC_RST);
        check("conv idle", 16'(starts), 16'h0);
        for (int c = 0; c < NUM_CHAN; c++) begin
            wr(lim_addr(c, 1), c == 0 ? 8'h19 : 8'hff);
            wr(lim_addr(c, 0), c == 0 ? 8'hd8 : 8'h00);
        end
        wr(A_CFG, 8'h10);
        low_len(n);
        check("gated pulse", 16'(n), 16'h0);
        wr(A_MSK2, 8'h80);
        wr(A_DAC, 8'h5a);
        wr(A_CFG, 8'h10);
        low_len(n);
        check("sw pulse", 16'(n >= P_PULSE), 16'h1);
        rchk(A_CFG, 8'h00);
        rchk(A_MSK2, 8'h80);
        wr(A_CFG, 8'h10);
        repeat (10) @(posedge clk);
        wr(A_CFG, 8'h10);
        low_len(n);
        check("restart", 16'(n >= P_PULSE), 16'h1);
        repeat (10) @(posedge clk);
        ext_low <= 1'b1;
        // release the outside pull while the device already holds the pin
        fork
            begin
                repeat (6) @(posedge clk);
                ext_low <= 1'b0;
            end
            low_len(n);
        join
        check("ext pulse", 16'(n >= P_PULSE), 16'h1);
        rchk(A_MSK2, 8'h00);
        rchk(A_DAC, 8'h5a);
        v = 8'($urandom_range(1, 255));
        wr(A_MSK1, v);
        wr(A_CFG, 8'h80);
        low_len(n);
        check("init no pulse", 16'(n), 16'h0);
        rchk(A_MSK1, 8'h00);
        rchk(A_CFG, CFG_RST);
        rchk(lim_addr(0, 1), 8'h19);
        rchk(A_DAC, 8'h5a);
        check("dac pins", 16'(dac), 16'h5a);
        t1 = temp_byte(int'($urandom_range(0, 63)) - 39);
        h = 1'($urandom);
        temp <= {t1, h};
        volt <= 8'($urandom);
        wr(A_CFG, 8'h03);
        wait_starts(1);
        wr(A_CFG, 8'h02);
        wait_starts(9);
        repeat (3 * P_SLOT) @(posedge clk);
        check("loop stopped", 16'(starts), 16'd9);
        rchk(A_TEMP, t1);
        rd(A_TCFG, v);
        check("half bit", 16'(v[TCFG_HALF]), 16'(h));
        check("int quiet", 16'(int_n), 16'h1);
        temp <= {temp_byte(125), 1'b0};
        wr(A_CFG, 8'h03);
        wait_starts(13);
        rchk(A_TEMP, 8'h7d);
        wr(A_CFG, 8'h02);
        wait_starts(18);
        repeat (3 * P_SLOT) @(posedge clk);
        check("int low", 16'(int_n), 16'h0);
        wr(A_CFG, 8'h0b);
        repeat (2 * P_SLOT) @(posedge clk);
        #1;
        check("int cleared", 16'(int_n), 16'h1);
        check("halted", 16'(starts), 16'd18);
        wr(A_CFG, 8'h00);
        rchk(A_ST1, 8'h01);
        intrude <= 1'b1;
        @(posedge clk);
        intrude <= 1'b0;
        repeat (6) @(posedge clk);
        rd(A_ST2, v);
        check("chassis seen", 16'(v[ST2_CHS]), 16'h1);
        wr(A_CFG, 8'h40);
        repeat (2) @(posedge clk);
        #1;
        check("chassis drive", 16'({chs_oe, chs_pin}), 16'h0);
        wr(A_CFG, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        check("latch cleared", 16'({chs_oe, chs_pin}), 16'h2);
        stop_test();
    end
endmodule : tb_top
